/* File: test/serial_partner.sv */
/* remote serial end: sends frames on rxd_in, samples txd_out.
   assumes the caller enters a task right after a clock edge. */
`timescale 1ns/1ps
module serial_partner (
  // clock
  input wire logic ref_clk,
  // line
  input wire logic txd_out,
  output logic rxd_in
);
  initial rxd_in = 1'b1;

  // lsb first, 16 clocks a bit; line rests at mark after each call
  task automatic send(input logic [23:0] bits, input int n);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxd_in <= bits[i];
      repeat (16) @(posedge ref_clk);
    end
    rxd_in <= 1'b1;
  endtask : send

  // waits for a start bit, then samples n bits mid-bit; ok low on hang
  task automatic recv(input int clks, input int n,
      output logic [23:0] bits, output logic ok);
    int w;
    bits = '0;
    w = 0;
    while (txd_out !== 1'b0 && w < 400) begin
      @(posedge ref_clk);
      w++;
    end
    ok = (w < 400);
    repeat (clks / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (clks) @(posedge ref_clk);
      bits[i] = txd_out;
    end
  endtask : recv
endmodule : serial_partner

/* File: test/testbench.sv */
/* bench for one serial channel: apb tasks and scenario sequence.
   assumes divisor 1 after reset, so 16 clocks per bit. */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
  end \
end
module testbench import uart_lmc_pkg::*; ;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_in, txd_out, dtr_n, rts_n, aux_n;
  logic int_out, int_oe, ok, pb, last_err;
  logic irq_src = 0;
  logic [7:0] rv, f, d;
  logic [23:0] got, ex;
  int num_errors = 0, compares = 0, n, nb;
  logic [7:0] fmts [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b,
      8'h2b, 8'h3b, 8'h07, 8'h04};

  // 25 MHz
  always #20 ref_clk = ~ref_clk;

  uart_lmc DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_in), .txd_out(txd_out), .ring_indicate_in(1'b1),
    .dtr_n(dtr_n), .rts_n(rts_n), .aux_output_two_n(aux_n),
    .irq_src(irq_src), .int_out(int_out), .int_oe(int_oe));
  serial_partner PARTNER (.ref_clk(ref_clk), .txd_out(txd_out),
    .rxd_in(rxd_in));

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // one transfer; an idle edge first keeps psel from changing twice
  task automatic apb(input logic wr, input logic [2:0] idx,
      input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {7'h00, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      num_errors++;
      print_verdict();
    end
    rv = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [2:0] idx, input logic [7:0] m,
      input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rv & m, e)
  endtask : rchk

  // bounded wait for a status pattern
  task automatic poll(input logic [2:0] idx, input logic [7:0] m,
      input logic [7:0] e);
    int k;
    k = 0;
    do begin
      apb(1'b0, idx, 8'h00);
      k++;
    end while ((rv & m) !== e && k < 250);
    `CHK(rv & m, e)
  endtask : poll

  function automatic logic [23:0] fr(input logic [7:0] c);
    fr = {14'h0000, 1'b1, c, 1'b0};
  endfunction : fr

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    `CHK({dtr_n, rts_n, aux_n, int_oe, txd_out}, 5'b11101)
    rchk(IDX_LFC, 8'hff, LFC_RST);
    rchk(IDX_MOC, 8'hff, MOC_RST);
    rchk(IDX_LST, 8'hff, 8'h60);
    apb(1'b0, IDX_DIVHI, 8'h00);
    `CHK(last_err, 1'b1)
    apb(1'b1, IDX_LFC, 8'h83);
    apb(1'b1, IDX_DATA, 8'h01);
    rchk(IDX_DATA, 8'hff, 8'h01);
    rchk(IDX_LST, 8'h40, 8'h40);
    apb(1'b1, IDX_LFC, 8'h03);
    irq_src <= 1'b1;
    apb(1'b1, IDX_MOC, 8'h0b);
    @(posedge ref_clk);
    `CHK({dtr_n, rts_n, aux_n, int_oe, int_out}, 5'b00011)
    apb(1'b1, IDX_MOC, 8'h00);
    @(posedge ref_clk);
    `CHK({dtr_n, rts_n, aux_n, int_oe}, 4'b1110)
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      f = fmts[i];
      n = 5 + int'(f[1:0]);
      d = 8'hb5 & ~(8'hff << n);
      pb = f[5] ? ~f[4] : (^d) ^ ~f[4];
      ex = {16'h0000, d};
      nb = n;
      if (f[3]) begin
        ex[nb] = pb;
        nb++;
      end
      // a queued second char puts its start bit right after the stops
      ex[nb] = 1'b1;
      ex[nb + 1] = f[2];
      nb = nb + 2 + int'(f[2]);
      apb(1'b1, IDX_LFC, f);
      fork
        PARTNER.recv(16, nb, got, ok);
        begin
          apb(1'b1, IDX_DATA, 8'hb5);
          apb(1'b1, IDX_DATA, 8'hb5);
          rchk(IDX_LST, 8'h40, 8'h00);
        end
      join
      `CHK({ok, got}, {1'b1, ex})
      poll(IDX_LST, 8'h60, 8'h60);
    end
    apb(1'b1, IDX_DATA, 8'h11);
    apb(1'b1, IDX_DATA, 8'h22);
    rchk(IDX_LST, 8'h20, 8'h00);
    poll(IDX_LST, 8'h60, 8'h60);
    $display("test transmit done");
    apb(1'b1, IDX_LFC, 8'h1b);
    PARTNER.send({13'h0000, 2'h3, 8'ha5, 1'b0}, 11);
    poll(IDX_LST, 8'h01, 8'h01);
    rchk(IDX_LST, 8'hff, 8'he5);
    rchk(IDX_DATA, 8'hff, 8'ha5);
    rchk(IDX_LST, 8'hff, 8'h60);
    apb(1'b1, IDX_LFC, 8'h03);
    PARTNER.send({15'h0000, 8'h5a, 1'b0}, 10);
    poll(IDX_LST, 8'h01, 8'h01);
    rchk(IDX_LST, 8'hff, 8'he9);
    rchk(IDX_DATA, 8'hff, 8'h5a);
    PARTNER.send(24'h000000, 24);
    poll(IDX_LST, 8'h11, 8'h11);
    rchk(IDX_DATA, 8'hff, 8'h00);
    rchk(IDX_LST, 8'hff, 8'h60);
    for (int i = 0; i < 17; i++) PARTNER.send(fr(8'h30 + i[7:0]), 10);
    poll(IDX_LST, 8'h02, 8'h02);
    rchk(IDX_LST, 8'h02, 8'h00);
    for (int i = 0; i < 16; i++) begin
      rchk(IDX_DATA, 8'hff, 8'h30 + i[7:0]);
    end
    rchk(IDX_LST, 8'h01, 8'h00);
    $display("test receive done");
    apb(1'b1, IDX_MOC, 8'h14);
    rchk(IDX_MST, 8'h40, 8'h40);
    apb(1'b1, IDX_DATA, 8'h3c);
    repeat (20) @(posedge ref_clk);
    `CHK(txd_out, 1'b1)
    poll(IDX_LST, 8'h01, 8'h01);
    rchk(IDX_DATA, 8'hff, 8'h3c);
    apb(1'b1, IDX_MOC, 8'h80);
    fork
      PARTNER.recv(64, 9, got, ok);
      apb(1'b1, IDX_DATA, 8'h96);
    join
    `CHK({ok, got}, 25'h1000196)
    poll(IDX_LST, 8'h40, 8'h40);
    apb(1'b1, IDX_FLOW, 8'h01);
    apb(1'b1, IDX_MOC, 8'h20);
    fork
      PARTNER.recv(16, 9, got, ok);
      begin
        apb(1'b1, IDX_DATA, 8'h5a);
        repeat (40) @(posedge ref_clk);
        `CHK(txd_out, 1'b1)
        PARTNER.send(fr(8'h41), 10);
      end
    join
    `CHK({ok, got}, 25'h100015a)
    rchk(IDX_DATA, 8'hff, 8'h41);
    // software flow on: an xon is dropped, the next char is kept
    apb(1'b1, IDX_FLOW, 8'h02);
    PARTNER.send(fr(XON_CHAR), 10);
    PARTNER.send(fr(8'h42), 10);
    poll(IDX_LST, 8'h01, 8'h01);
    rchk(IDX_DATA, 8'hff, 8'h42);
    $display("test modem modes done");
    apb(1'b1, IDX_MOC, 8'h00);
    apb(1'b1, IDX_LFC, 8'h43);
    repeat (3) @(posedge ref_clk);
    `CHK(txd_out, 1'b0)
    apb(1'b1, IDX_LFC, 8'h03);
    repeat (3) @(posedge ref_clk);
    `CHK(txd_out, 1'b1)
    apb(1'b1, IDX_MOC, 8'h40);
    repeat (3) @(posedge ref_clk);
    `CHK(txd_out, 1'b0)
    $display("test break and infrared done");
    print_verdict();
  end
endmodule : testbench

/* File: verilog/uart_lmc.sv */
/*
 * One serial channel: APB register slave, baud generator with
 * prescaler, transmit holding register, receive FIFO with error tags,
 * loopback, IrDA coding and modem outputs. Assumes an APB master on
 * ref_clk and a remote serial partner on the pins.
 */
`timescale 1ns/1ps
// Overview of operation
// - Two low format bits pick 5, 6, 7 or 8 data bits.
// - Stop bit set: 1.5 stops for 5-bit, else 2 stops.
// - Parity enable adds parity on transmit and checks on receive.
// - Parity type clear gives odd parity, set gives even.
// - Forced parity: constant one when type clear, zero when set.
// - Break bit holds the transmit pin low until cleared.
// - Divisor access bit maps data addresses to the divisor latch.
// - Terminal-ready pin is the inverse of its control bit.
// - Request-to-send pin is the inverse of its control bit.
// - Control bit two feeds the ring state in loopback.
// - Output-two bit enables interrupt pin, drives aux output low.
// - Loopback bit turns on internal local loopback.
// - Resume-any: any character resumes transmit; Xon/Xoff dropped under software flow.
// - Infrared bit routes through IrDA coding; idle output low.
// - Prescaler bit divides the clock by four before the divisor.
// - Data-ready reads one while a received character waits.
// - Character into full FIFO sets overrun and is discarded.
// - Parity tag belongs to the character at the FIFO head.
// - Framing tag belongs to the character at the FIFO head.
// - Break stores one character, then waits for the line high.
// - Holding-empty sets on move to shifter, clears on load.
// - Transmitter-empty only when holding and shift both empty.
// - Error summary set while any stored character has a tag.
module uart_lmc import uart_lmc_pkg::*; #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd_in,
  output logic txd_out,
  // modem pins
  input wire logic ring_indicate_in,
  output logic dtr_n,
  output logic rts_n,
  output logic aux_output_two_n,
  // interrupt pin, three-state
  input wire logic irq_src,
  output logic int_out,
  output logic int_oe
);
  localparam int PW = $clog2(DEPTH);

  logic [7:0] line_format_control;
  logic [7:0] modem_output_control;
  logic [15:0] baud_divisor_latch;
  logic [1:0] flow_ctrl;
  logic [7:0] tx_holding_reg;
  logic thr_empty;
  logic overrun;
  logic [10:0] fifo_mem [DEPTH];
  logic [PW-1:0] wp, rp;
  logic [PW:0] fifo_cnt, err_cnt;
  logic [1:0] pre_cnt;
  logic [15:0] div_cnt;
  logic tick;
  logic rx_s1, rx_s2, ri_s1, ri_s2;
  logic [4:0] ir_cnt;
  logic tx_busy, tx_line, tx_start;
  logic [3:0] tx_phase;
  logic rx_line, rx_done, rx_pe, rx_fe, rx_brk;
  logic [7:0] rx_data;
  logic [7:0] line_status;
  logic [10:0] head;
  logic wr_acc, rd_setup, rd_acc, sel_ok, dlab;
  logic [2:0] idx;
  logic push, pop, fifo_full, keep_char, err_in, ring_state;
  logic [7:0] next_rdata;

  assign dlab = line_format_control[7];
  assign idx = paddr[4:2];
  assign sel_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) &&
                  (idx != 3'h2) && (idx != IDX_DIVHI || dlab);
  assign wr_acc = psel && penable && pwrite && sel_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_acc = psel && penable && !pwrite && sel_ok;
  // zero-wait slave; bad addresses answer with an error
  assign pready = psel && penable;
  assign pslverr = psel && penable && !sel_ok;

  // input synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      ri_s1 <= 1'b1;
      ri_s2 <= 1'b1;
    end else begin
      rx_s1 <= rxd_in;
      rx_s2 <= rx_s1;
      ri_s1 <= ring_indicate_in;
      ri_s2 <= ri_s1;
    end
  end

  // control registers; reset returns every format bit to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_format_control <= LFC_RST;
      modem_output_control <= MOC_RST;
      baud_divisor_latch <= DIV_RST;
    end else if (wr_acc) begin
      case (idx)
        IDX_DATA: begin
          if (dlab) begin
            baud_divisor_latch[7:0] <= pwdata[7:0];
          end
        end
        IDX_DIVHI: baud_divisor_latch[15:8] <= pwdata[7:0];
        IDX_LFC: line_format_control <= pwdata[7:0];
        IDX_MOC: modem_output_control <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // prescaler then divisor; a zero divisor stops the ticks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 2'h0;
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      pre_cnt <= pre_cnt + 2'h1;
      if (!modem_output_control[7] || pre_cnt == PRESCALE_MAX) begin
        div_cnt <= div_cnt + 16'h0001;
        if (div_cnt + 16'h0001 >= baud_divisor_latch) begin
          div_cnt <= 16'h0000;
          tick <= (baud_divisor_latch != 16'h0000);
        end
      end
    end
  end

  // suspend bit set by software, released by any character when resume-any is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_ctrl <= FLOW_RST;
    end else if (wr_acc && idx == IDX_FLOW) begin
      flow_ctrl <= pwdata[1:0];
    end else if (rx_done && modem_output_control[5]) begin
      flow_ctrl[0] <= 1'b0;
    end
  end

  // holding register: load clears empty, move to shifter sets it
  assign tx_start = !thr_empty && !tx_busy && !flow_ctrl[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_empty <= 1'b1;
      tx_holding_reg <= 8'h00;
    end else if (wr_acc && idx == IDX_DATA && !dlab) begin
      thr_empty <= 1'b0;
      tx_holding_reg <= pwdata[7:0];
    end else if (tx_start) begin
      thr_empty <= 1'b1;
    end
  end

  uart_lmc_tx u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .start(tx_start),
    .data(tx_holding_reg),
    .wl(line_format_control[1:0]),
    .stop_sel(line_format_control[2]),
    .par_en(line_format_control[3]),
    .par_even(line_format_control[4]),
    .par_stick(line_format_control[5]),
    .busy(tx_busy),
    .txd(tx_line),
    .phase(tx_phase)
  );

  // ir decoder stretches each short high pulse into a low bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_cnt <= 5'h00;
    end else if (rx_s2) begin
      ir_cnt <= IR_STRETCH;
    end else if (tick && ir_cnt != 5'h00) begin
      ir_cnt <= ir_cnt - 5'h01;
    end
  end

  always_comb begin
    if (modem_output_control[4]) begin
      rx_line = tx_line;
    end else if (modem_output_control[6]) begin
      rx_line = (ir_cnt == 5'h00);
    end else begin
      rx_line = rx_s2;
    end
  end

  uart_lmc_rx u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .rxd(rx_line),
    .wl(line_format_control[1:0]),
    .par_en(line_format_control[3]),
    .par_even(line_format_control[4]),
    .par_stick(line_format_control[5]),
    .done(rx_done),
    .data(rx_data),
    .pe(rx_pe),
    .fe(rx_fe),
    .brk(rx_brk)
  );

  // transmit pin: break wins, loopback idles at mark, ir encodes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_out <= 1'b1;
    end else if (line_format_control[6]) begin
      txd_out <= 1'b0;
    end else if (modem_output_control[4]) begin
      txd_out <= 1'b1;
    end else if (modem_output_control[6]) begin
      txd_out <= !tx_line && tx_phase < IR_PULSE;
    end else begin
      txd_out <= tx_line;
    end
  end

  // receive fifo; xon/xoff are not stored under software flow with resume-any set
  assign keep_char = !(flow_ctrl[1] && modem_output_control[5] &&
                       (rx_data == XON_CHAR || rx_data == XOFF_CHAR));
  assign fifo_full = (fifo_cnt == DEPTH[PW:0]);
  assign pop = rd_acc && idx == IDX_DATA && !dlab && fifo_cnt != '0;
  assign push = rx_done && keep_char && !fifo_full;
  assign err_in = rx_pe || rx_fe || rx_brk;
  assign head = fifo_mem[rp];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem[wp] <= {rx_brk, rx_fe, rx_pe, rx_data};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      fifo_cnt <= '0;
      err_cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      fifo_cnt <= fifo_cnt + (PW+1)'(push) - (PW+1)'(pop);
      // summary counts tagged entries so it clears with the last one
      err_cnt <= err_cnt + (PW+1)'(push && err_in) -
                 (PW+1)'(pop && head[10:8] != 3'h0);
    end
  end

  // overrun: a new event beats the clear by a status read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (rx_done && keep_char && fifo_full) begin
      overrun <= 1'b1;
    end else if (rd_acc && idx == IDX_LST) begin
      overrun <= 1'b0;
    end
  end

  always_comb begin
    line_status[0] = (fifo_cnt != '0);
    line_status[1] = overrun;
    line_status[2] = line_status[0] && head[8];
    line_status[3] = line_status[0] && head[9];
    line_status[4] = line_status[0] && head[10];
    line_status[5] = thr_empty;
    line_status[6] = thr_empty && !tx_busy;
    line_status[7] = (err_cnt != '0);
  end

  assign ring_state = modem_output_control[4] ?
                      modem_output_control[2] : !ri_s2;

  always_comb begin
    next_rdata = 8'h00;
    case (idx)
      IDX_DATA: next_rdata = dlab ? baud_divisor_latch[7:0] : head[7:0];
      IDX_DIVHI: next_rdata = dlab ? baud_divisor_latch[15:8] : 8'h00;
      IDX_LFC: next_rdata = line_format_control;
      IDX_MOC: next_rdata = modem_output_control;
      IDX_LST: next_rdata = line_status;
      IDX_MST: next_rdata = {1'b0, ring_state, 6'h00};
      IDX_FLOW: next_rdata = {6'h00, flow_ctrl};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data caught in the setup cycle, stable through access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, sel_ok ? next_rdata : 8'h00};
    end
  end

  // modem outputs are inverted control bits
  assign dtr_n = !modem_output_control[0];
  assign rts_n = !modem_output_control[1];
  assign aux_output_two_n = !modem_output_control[3];
  assign int_oe = modem_output_control[3];
  assign int_out = irq_src;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_break_low: assert property (line_format_control[6] |=> !txd_out)
    else $error("break bit set but transmit pin not low");
  a_div_access: assert property (
    wr_acc && idx == IDX_DATA && dlab |=>
      baud_divisor_latch[7:0] == $past(pwdata[7:0]) && tx_holding_reg ==
      $past(tx_holding_reg))
    else $error("divisor write did not reach the latch");
  a_dtr_follow: assert property (
    wr_acc && idx == IDX_MOC |=> dtr_n == !$past(pwdata[0]))
    else $error("terminal-ready pin not inverse of written bit");
  a_rts_follow: assert property (
    wr_acc && idx == IDX_MOC |=> rts_n == !$past(pwdata[1]))
    else $error("request-to-send pin not inverse of written bit");
  a_loop_ring: assert property (
    modem_output_control[4] |-> ring_state == modem_output_control[2])
    else $error("loopback ring state wrong");
  a_aux_int: assert property (int_oe != aux_output_two_n)
    else $error("aux output and interrupt enable disagree");
  a_ir_idle: assert property (
    !tx_busy ##1 (modem_output_control[6] && !modem_output_control[4] &&
    !line_format_control[6] && !tx_busy) |=> !txd_out)
    else $error("ir output not low while idle");
  a_ready_level: assert property (push |=> line_status[0])
    else $error("data ready not set after a store");
  a_overrun_set: assert property (
    rx_done && keep_char && fifo_full |=> overrun &&
      fifo_cnt == $past(fifo_cnt) - (PW+1)'($past(pop)))
    else $error("overrun not flagged or fifo altered");
  a_thre_load: assert property (
    wr_acc && idx == IDX_DATA && !dlab |=> !thr_empty)
    else $error("holding empty not cleared on load");
  a_temt_both: assert property (
    tx_start |=> !line_status[6])
    else $error("transmitter empty while data held");
  a_err_clear: assert property (fifo_cnt == '0 |-> !line_status[7])
    else $error("error summary set with empty fifo");

  c_overrun: cover property (rx_done && fifo_full);
  c_break: cover property (push && rx_brk);
  c_parity: cover property (push && rx_pe);
  c_tx_frame: cover property (tx_start ##[1:1000] !tx_busy);
endmodule : uart_lmc

/* File: verilog/uart_lmc_pkg.sv */
/*
 * Shared constants for the line-format, modem-output and line-status
 * block: register indices, reset values, bit timing, frame states and
 * the parity helper. Assumes a 16x oversampling tick from the baud
 * generator.
 */
package uart_lmc_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0; // rx/tx data or divisor low
  localparam logic [2:0] IDX_DIVHI = 3'h1; // divisor high (dlab only)
  localparam logic [2:0] IDX_LFC = 3'h3;
  localparam logic [2:0] IDX_MOC = 3'h4;
  localparam logic [2:0] IDX_LST = 3'h5;
  localparam logic [2:0] IDX_MST = 3'h6;
  localparam logic [2:0] IDX_FLOW = 3'h7;
  // values after reset
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [7:0] MOC_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [1:0] FLOW_RST = 2'h0;
  // bit timing in 16x ticks
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2 = 6'h20;
  localparam logic [3:0] IR_PULSE = 4'h3; // 3/16 of a bit
  localparam logic [4:0] IR_STRETCH = 5'h10;
  localparam logic [1:0] PRESCALE_MAX = 2'h3; // divide by four
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100,
    ST_WAIT = 3'b101
  } frame_state_t;

  // parity bit for a character of 5 + wl bits
  function automatic logic calc_par(input logic [7:0] d,
      input logic [1:0] wl, input logic even, input logic stick);
    logic [7:0] mask;
    mask = 8'h1f;
    mask = mask | {wl == 2'h3, wl >= 2'h2, wl >= 2'h1, 5'h00};
    if (stick) begin
      calc_par = ~even;
    end else begin
      calc_par = (^(d & mask)) ^ ~even;
    end
  endfunction : calc_par
endpackage : uart_lmc_pkg

/* File: verilog/uart_lmc_rx.sv */
/*
 * Receive engine: samples mid-bit, checks parity and stop, flags
 * break. Assumes a synchronised line and a 16x tick.
 */
`timescale 1ns/1ps
module uart_lmc_rx import uart_lmc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // line and format
  input wire logic tick,
  input wire logic rxd,
  input wire logic [1:0] wl,
  input wire logic par_en,
  input wire logic par_even,
  input wire logic par_stick,
  // character out
  output logic done,
  output logic [7:0] data,
  output logic pe,
  output logic fe,
  output logic brk
);
  frame_state_t state;
  logic [5:0] cnt;
  logic [2:0] bitn;
  logic pbit;

  // after a low stop bit, wait for mark so one break makes one char
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      bitn <= 3'h0;
      pbit <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      pe <= 1'b0;
      fe <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          cnt <= 6'h00;
          if (!rxd) begin
            state <= ST_START;
          end
        end
        ST_WAIT: begin
          if (rxd) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          if (tick) begin
            cnt <= cnt + 6'h01;
            if (state == ST_START && cnt == TICKS_HALF - 6'h01) begin
              cnt <= 6'h00;
              bitn <= 3'h0;
              data <= 8'h00;
              state <= rxd ? ST_IDLE : ST_DATA;
            end else if (state != ST_START &&
                         cnt == TICKS_BIT - 6'h01) begin
              cnt <= 6'h00;
              case (state)
                ST_DATA: begin
                  data[bitn] <= rxd;
                  bitn <= bitn + 3'h1;
                  if (bitn == {1'b0, wl} + 3'h4) begin
                    state <= par_en ? ST_PAR : ST_STOP;
                  end
                end
                ST_PAR: begin
                  pbit <= rxd;
                  state <= ST_STOP;
                end
                default: begin
                  done <= 1'b1;
                  fe <= !rxd;
                  pe <= par_en &&
                    (pbit != calc_par(data, wl, par_even, par_stick));
                  brk <= !rxd && data == 8'h00 &&
                    !(par_en && pbit);
                  state <= rxd ? ST_IDLE : ST_WAIT;
                end
              endcase
            end
          end
        end
      endcase
    end
  end
endmodule : uart_lmc_rx

/* File: verilog/uart_lmc_tx.sv */
/*
 * Transmit shift engine: start bit, 5..8 data bits, optional parity,
 * 1, 1.5 or 2 stop bits. Assumes one tick per sixteenth of a bit.
 */
`timescale 1ns/1ps
module uart_lmc_tx import uart_lmc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  // format
  input wire logic [1:0] wl,
  input wire logic stop_sel,
  input wire logic par_en,
  input wire logic par_even,
  input wire logic par_stick,
  // line
  output logic busy,
  output logic txd,
  output logic [3:0] phase
);
  frame_state_t state;
  logic [5:0] cnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic par;
  logic [5:0] limit;
  logic line_bit;

  // stop length depends on word length
  always_comb begin
    limit = TICKS_BIT;
    if (state == ST_STOP && stop_sel) begin
      limit = (wl == 2'h0) ? TICKS_STOP15 : TICKS_STOP2;
    end
  end

  // frame sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      bitn <= 3'h0;
      shreg <= 8'h00;
      par <= 1'b0;
    end else if (state == ST_IDLE) begin
      if (start) begin
        state <= ST_START;
        cnt <= 6'h00;
        bitn <= 3'h0;
        shreg <= data;
        par <= calc_par(data, wl, par_even, par_stick);
      end
    end else if (tick) begin
      cnt <= cnt + 6'h01;
      if (cnt == limit - 6'h01) begin
        cnt <= 6'h00;
        case (state)
          ST_START: state <= ST_DATA;
          ST_DATA: begin
            shreg <= {1'b0, shreg[7:1]};
            bitn <= bitn + 3'h1;
            if (bitn == {1'b0, wl} + 3'h4) begin
              state <= par_en ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: state <= ST_STOP;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (state)
      ST_START: line_bit = 1'b0;
      ST_DATA: line_bit = shreg[0];
      ST_PAR: line_bit = par;
      default: line_bit = 1'b1;
    endcase
  end

  // registered line keeps glitches off the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd <= 1'b1;
    end else begin
      txd <= line_bit;
    end
  end

  assign busy = (state != ST_IDLE);
  assign phase = cnt[3:0];
endmodule : uart_lmc_tx
